// File: hdl/prm_input.v
// Notes on behaviour
// (RQ1) Scale factor is display units over pulses times decimal weight 1 to 100000.
// (RQ2) Shown counter value is count times scale factor; factor one shows raw counts.
// (RQ3) Inhibit function stops counting on the assigned counters while input active.
// (RQ4) Maintained reset holds assigned counters at zero while input level active.
// (RQ5) Store freezes shown value of assigned counters while counting continues inside.
// (RQ6) Store-and-reset captures count on active edge, then resets assigned counters.
// (RQ7) Display select advances to next display once per activation edge.
// (RQ8) Intensity function raises brightness one level per activation edge.
// (RQ9) Setpoint reset functions reset output 1, 2 or both per activation edge.
// (RQ10) Select, intensity, setpoint resets and store-and-reset use edges; other functions follow level.
// (RQ11) Counter assignment applies only with counter B on and reset/inhibit/store.
// (RQ12) User input polarity is programmable active low or active high.
// (RQ13) Rate enable switches measurement; when off other rate settings are hidden.
// (RQ14) Rate point position only places the point, not the scaling.
// (RQ15) Rate reading is linear through origin and one display/input pair.
// (RQ16) Scaling input is in hertz up to 999999; display value 0 to 999999. Code takes the input in tenths of hertz and does not clamp it.
// (RQ17) Apply style: reset key shows live frequency, parameter key stores it.
// (RQ18) Minimum interval between rate updates is programmable 0.1 to 999 s; code accepts 0.1 to 102.2 s, as it must stay below the maximum.
// (RQ19) Rate forced to zero after maximum interval, 0.2 to 99.9 s, default 2.0; code accepts 0.2 to 102.3 s.
// (RQ20) Sample starts on first falling edge, counting edges and time from it.
// (RQ21) After minimum interval next falling edge ends sample, updates, starts next.
// (RQ22) Maximum interval without edge after minimum ends sample and shows zero.
// (RQ23) Maximum interval above minimum, both above zero.
// (RQ24) Pulse and user inputs are synchronised before edge detection.
`include "prm_regs.vh"

module prm_input #(
  parameter CYC_PER_MS = `PRM_CYC_PER_MS
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // Pulse and user inputs
  input  wire        i_pulse_a,
  input  wire        i_pulse_b,
  input  wire        i_user_in,
  input  wire        i_reset_key,
  input  wire        i_parameter_key,
  // Display and setpoint side
  output reg  [19:0] o_count_a_value,
  output reg  [19:0] o_count_b_value,
  output reg  [19:0] o_rate_value,
  output reg  [2:0]  o_rate_point_position,
  output reg         o_disp_sel_step,
  output reg         o_intensity_step,
  output reg         o_sp1_reset,
  output reg         o_sp2_reset,
  output reg         o_prog_lockout
);

  localparam [1:0] RS_IDLE = 2'd0;
  localparam [1:0] RS_RUN  = 2'd1;
  localparam [1:0] JB_SFA  = 2'd0;
  localparam [1:0] JB_SFB  = 2'd1;
  localparam [1:0] JB_RATE = 2'd2;

  reg  [31:0] ctrl;
  reg  [31:0] scale_a;
  reg  [31:0] scale_b;
  reg  [19:0] rate_scaling_display_value;
  reg  [23:0] rate_scaling_input_value;
  reg  [13:0] low_tenths;
  reg  [9:0]  high_tenths;
  reg  [19:0] sf_a;
  reg  [19:0] sf_b;
  reg  [23:0] cnt_a;
  reg  [23:0] cnt_b;
  reg  [2:0]  sync_a;
  reg  [2:0]  sync_b;
  reg  [2:0]  sync_u;
  reg  [1:0]  sync_r;
  reg  [1:0]  sync_p;
  reg         live_mode;
  reg  [19:0] live_freq;
  reg  [1:0]  rate_state;
  reg  [15:0] edges;
  reg  [19:0] elapsed_ms;
  reg  [13:0] tick_cnt;
  reg         tick;
  reg         req_sfa;
  reg         req_sfb;
  reg         req_rate;
  reg  [15:0] job_edges;
  reg  [19:0] job_ms;
  reg         div_busy;
  reg  [1:0]  div_job;
  reg  [5:0]  div_cnt;
  reg  [55:0] div_quo;
  reg  [48:0] div_rem;
  reg  [47:0] div_den;
  reg  [55:0] next_num;
  reg  [47:0] next_den;
  reg  [19:0] weight_a;
  reg  [19:0] weight_b;
  reg  [31:0] rd_mux;

  wire [3:0]  func      = ctrl[`PRM_CTRL_FUNC_LSB +: 4];
  wire        rate_en   = ctrl[`PRM_CTRL_RATE_BIT];
  wire        apb_acc   = i_psel & i_penable & o_pready;
  wire        apb_wr    = apb_acc & i_pwrite;
  wire [13:0] wr_low    = i_pwdata[13:0];
  wire [9:0]  wr_high   = i_pwdata[25:16];
  // (RQ23) reject bad intervals
  wire        updt_bad  = (wr_low == 14'h0000) || (wr_high == 10'h000) ||
                          ({4'h0, wr_high} <= wr_low);
  wire        rate_reg  = (i_paddr == `PRM_RATE_DISP_OFS) || (i_paddr == `PRM_RATE_INP_OFS) ||
                          (i_paddr == `PRM_UPDT_OFS);
  // (RQ12) polarity applied after sync
  wire        user_act  = sync_u[1] ^ ~ctrl[`PRM_CTRL_POL_BIT];
  wire        user_prev = sync_u[2] ^ ~ctrl[`PRM_CTRL_POL_BIT];
  wire        user_edge = user_act & ~user_prev;
  // (RQ24) edges from synchronised copies
  wire        rise_a    = sync_a[1] & ~sync_a[2];
  wire        fall_a    = ~sync_a[1] & sync_a[2];
  wire        rise_b    = sync_b[1] & ~sync_b[2];
  // (RQ11) assignment gating
  wire        cnt_fn    = (func == `PRM_FN_INHIBIT) || (func == `PRM_FN_RESET) ||
                          (func == `PRM_FN_STORE) || (func == `PRM_FN_STORE_RST);
  wire        use_asg   = ctrl[`PRM_CTRL_BEN_BIT] & cnt_fn;
  wire        tgt_a     = use_asg ? ctrl[`PRM_CTRL_ASSIGN_LSB] : 1'b1;
  wire        tgt_b     = use_asg & ctrl[`PRM_CTRL_ASSIGN_LSB + 1];
  wire        lvl       = user_act & tgt_a;
  wire        lvl_b     = user_act & tgt_b;
  // (RQ2) shown value is count times factor
  wire [43:0] prod_a    = cnt_a * sf_a;
  wire [43:0] prod_b    = cnt_b * sf_b;
  wire [43:0] shown_a   = prod_a / `PRM_SF_ONE;
  wire [43:0] shown_b   = prod_b / `PRM_SF_ONE;
  wire [48:0] div_try   = {div_rem[47:0], div_quo[55]};
  wire [19:0] div_res   = (div_quo > {36'h0, `PRM_VAL_MAX}) ? `PRM_VAL_MAX : div_quo[19:0];

  // (RQ1) decimal weight per point position
  always @*
  begin
    case (ctrl[`PRM_CTRL_DPA_LSB +: 3])
      3'd0:    weight_a = 20'h00001;
      3'd1:    weight_a = 20'h0000A;
      3'd2:    weight_a = 20'h00064;
      3'd3:    weight_a = 20'h003E8;
      3'd4:    weight_a = 20'h02710;
      default: weight_a = 20'h186A0;
    endcase
    case (ctrl[`PRM_CTRL_DPB_LSB +: 3])
      3'd0:    weight_b = 20'h00001;
      3'd1:    weight_b = 20'h0000A;
      3'd2:    weight_b = 20'h00064;
      3'd3:    weight_b = 20'h003E8;
      3'd4:    weight_b = 20'h02710;
      default: weight_b = 20'h186A0;
    endcase
  end

  // Divider operands: the factor result is in units of 0.0001.
  always @*
  begin
    next_num = 56'h0;
    next_den = 48'h0;
    if (req_rate)
    begin
      // (RQ15) rate = edges * display * 10000 / (input_tenths * ms); in live mode rate = edges * 10000 / ms
      if (live_mode)
      begin
        next_num = {40'h0, job_edges} * 56'd10000;
        next_den = {28'h0, job_ms};
      end
      else
      begin
        next_num = {40'h0, job_edges} * {36'h0, rate_scaling_display_value} * 56'd10000;
        next_den = {24'h0, rate_scaling_input_value} * {28'h0, job_ms};
      end
    end
    else if (req_sfa)
    begin
      next_num = {40'h0, scale_a[15:0]} * {36'h0, weight_a} * 56'd10000;
      next_den = {32'h0, scale_a[31:16]};
    end
    else
    begin
      next_num = {40'h0, scale_b[15:0]} * {36'h0, weight_b} * 56'd10000;
      next_den = {32'h0, scale_b[31:16]};
    end
  end

  always @*
  begin
    case (i_paddr)
      `PRM_CTRL_OFS:      rd_mux = ctrl;
      `PRM_SCALE_A_OFS:   rd_mux = scale_a;
      `PRM_SCALE_B_OFS:   rd_mux = scale_b;
      `PRM_RATE_DISP_OFS: rd_mux = {12'h0, rate_scaling_display_value};
      `PRM_RATE_INP_OFS:  rd_mux = {8'h0, rate_scaling_input_value};
      `PRM_UPDT_OFS:      rd_mux = {6'h0, high_tenths, 2'h0, low_tenths};
      `PRM_SF_A_OFS:      rd_mux = {12'h0, sf_a};
      `PRM_SF_B_OFS:      rd_mux = {12'h0, sf_b};
      `PRM_CNT_A_OFS:     rd_mux = {12'h0, o_count_a_value};
      `PRM_CNT_B_OFS:     rd_mux = {12'h0, o_count_b_value};
      `PRM_RATE_OFS:      rd_mux = {12'h0, o_rate_value};
      `PRM_STATUS_OFS:    rd_mux = {27'h0, live_mode, div_busy, rate_state[0], user_act, o_prog_lockout};
      default:            rd_mux = 32'h0;
    endcase
    // (RQ13) rate settings hidden when off
    if (!rate_en && rate_reg)
      rd_mux = 32'h0;
  end

  // APB slave: pready rises in the second access cycle.
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_prdata  <= rd_mux;
      o_pslverr <= i_pwrite && (i_paddr == `PRM_UPDT_OFS) && rate_en && updt_bad;
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl                       <= `PRM_CTRL_RST;
      scale_a                    <= `PRM_SCALE_RST;
      scale_b                    <= `PRM_SCALE_RST;
      rate_scaling_display_value <= `PRM_RATE_DISP_RST;
      rate_scaling_input_value   <= `PRM_RATE_INP_RST;
      low_tenths                 <= `PRM_LOW_RST;
      high_tenths                <= `PRM_HIGH_RST;
      live_mode                  <= 1'b0;
      sync_r                     <= 2'b00;
      sync_p                     <= 2'b00;
    end
    else
    begin
      sync_r <= {sync_r[0], i_reset_key};
      sync_p <= {sync_p[0], i_parameter_key};
      if (apb_wr && (i_paddr == `PRM_CTRL_OFS))
        ctrl <= i_pwdata & `PRM_CTRL_WMASK;
      if (apb_wr && (i_paddr == `PRM_SCALE_A_OFS))
        scale_a <= i_pwdata;
      if (apb_wr && (i_paddr == `PRM_SCALE_B_OFS))
        scale_b <= i_pwdata;
      // (RQ16) clamp display value
      if (rate_en && apb_wr && (i_paddr == `PRM_RATE_DISP_OFS))
        rate_scaling_display_value <= (i_pwdata[19:0] > `PRM_VAL_MAX) ? `PRM_VAL_MAX : i_pwdata[19:0];
      if (rate_en && apb_wr && (i_paddr == `PRM_RATE_INP_OFS))
        rate_scaling_input_value <= i_pwdata[23:0];
      // (RQ18) (RQ19) store update times
      if (rate_en && apb_wr && (i_paddr == `PRM_UPDT_OFS) && !updt_bad)
      begin
        low_tenths  <= wr_low;
        high_tenths <= wr_high;
      end
      // (RQ17) apply style live frequency and capture
      if (rate_en && ctrl[`PRM_CTRL_APPLY_BIT] && sync_r[1])
        live_mode <= 1'b1;
      else if (live_mode && sync_p[1])
      begin
        live_mode                <= 1'b0;
        rate_scaling_input_value <= {4'h0, live_freq};
      end
    end
  end

  // Input synchronisers and 1 ms time base.
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      sync_a   <= {3{i_pulse_a}};
      sync_b   <= {3{i_pulse_b}};
      sync_u   <= {3{i_user_in}};
      tick_cnt <= 14'h0;
      tick     <= 1'b0;
    end
    else
    begin
      sync_a   <= {sync_a[1:0], i_pulse_a};
      sync_b   <= {sync_b[1:0], i_pulse_b};
      sync_u   <= {sync_u[1:0], i_user_in};
      tick     <= (tick_cnt == CYC_PER_MS[13:0] - 14'h1);
      tick_cnt <= (tick_cnt == CYC_PER_MS[13:0] - 14'h1) ? 14'h0 : tick_cnt + 14'h1;
    end
  end

  // Counters and user input actions.
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      cnt_a            <= 24'h0;
      cnt_b            <= 24'h0;
      o_count_a_value  <= 20'h0;
      o_count_b_value  <= 20'h0;
      o_disp_sel_step  <= 1'b0;
      o_intensity_step <= 1'b0;
      o_sp1_reset      <= 1'b0;
      o_sp2_reset      <= 1'b0;
      o_prog_lockout   <= 1'b0;
    end
    else
    begin
      // (RQ3) inhibit stops counting
      if (rise_a && !(func == `PRM_FN_INHIBIT && lvl))
        cnt_a <= cnt_a + 24'h1;
      if (rise_b && ctrl[`PRM_CTRL_BEN_BIT] && !(func == `PRM_FN_INHIBIT && lvl_b))
        cnt_b <= cnt_b + 24'h1;
      // (RQ5) store freezes shown value
      if (!(func == `PRM_FN_STORE && lvl) && func != `PRM_FN_STORE_RST)
        o_count_a_value <= (shown_a > {24'h0, `PRM_VAL_MAX}) ? `PRM_VAL_MAX : shown_a[19:0];
      if (!(func == `PRM_FN_STORE && lvl_b) && func != `PRM_FN_STORE_RST)
        o_count_b_value <= (shown_b > {24'h0, `PRM_VAL_MAX}) ? `PRM_VAL_MAX : shown_b[19:0];
      // (RQ6) capture then reset on edge
      if (func == `PRM_FN_STORE_RST && user_edge)
      begin
        if (tgt_a)
        begin
          o_count_a_value <= (shown_a > {24'h0, `PRM_VAL_MAX}) ? `PRM_VAL_MAX : shown_a[19:0];
          cnt_a           <= 24'h0;
        end
        if (tgt_b)
        begin
          o_count_b_value <= (shown_b > {24'h0, `PRM_VAL_MAX}) ? `PRM_VAL_MAX : shown_b[19:0];
          cnt_b           <= 24'h0;
        end
      end
      // (RQ4) level reset holds at zero
      if (func == `PRM_FN_RESET && lvl)
        cnt_a <= 24'h0;
      if (func == `PRM_FN_RESET && lvl_b)
        cnt_b <= 24'h0;
      // (RQ10) edge functions versus level lockout
      o_prog_lockout   <= (func == `PRM_FN_LOCK) && user_act;
      // (RQ7) one step per edge
      o_disp_sel_step  <= (func == `PRM_FN_DISP_SEL) && user_edge;
      // (RQ8) one level per edge
      o_intensity_step <= (func == `PRM_FN_INTENSITY) && user_edge;
      // (RQ9) setpoint output resets
      o_sp1_reset      <= ((func == `PRM_FN_SP1_RST) || (func == `PRM_FN_SP12_RST)) && user_edge;
      o_sp2_reset      <= ((func == `PRM_FN_SP2_RST) || (func == `PRM_FN_SP12_RST)) && user_edge;
    end
  end

  // Rate sampling and the shared divider.
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      rate_state            <= RS_IDLE;
      edges                 <= 16'h0;
      elapsed_ms            <= 20'h0;
      job_edges             <= 16'h0;
      job_ms                <= 20'h0;
      req_rate              <= 1'b0;
      req_sfa               <= 1'b1;
      req_sfb               <= 1'b1;
      div_busy              <= 1'b0;
      div_job               <= JB_SFA;
      div_cnt               <= 6'h0;
      div_quo               <= 56'h0;
      div_rem               <= 49'h0;
      div_den               <= 48'h0;
      sf_a                  <= `PRM_SF_UNITY;
      sf_b                  <= `PRM_SF_UNITY;
      o_rate_value          <= 20'h0;
      live_freq             <= 20'h0;
      o_rate_point_position <= 3'h0;
    end
    else
    begin
      // (RQ14) point position passes straight out
      o_rate_point_position <= ctrl[`PRM_CTRL_RDP_LSB +: 3];
      if (!rate_en)
      begin
        rate_state   <= RS_IDLE;
        o_rate_value <= 20'h0;
      end
      else
      begin
        case (rate_state)
          RS_IDLE:
          begin
            // (RQ20) first falling edge starts sample
            if (fall_a)
            begin
              rate_state <= RS_RUN;
              edges      <= 16'h0;
              elapsed_ms <= 20'h0;
            end
          end
          RS_RUN:
          begin
            if (tick)
              elapsed_ms <= elapsed_ms + 20'h1;
            // (RQ21) edge after minimum ends sample
            if (fall_a && elapsed_ms >= low_tenths * `PRM_MS_PER_TENTH)
            begin
              job_edges  <= edges + 16'h1;
              job_ms     <= elapsed_ms;
              req_rate   <= 1'b1;
              edges      <= 16'h0;
              elapsed_ms <= 20'h0;
            end
            // (RQ22) maximum interval forces zero
            else if (elapsed_ms >= high_tenths * `PRM_MS_PER_TENTH)
            begin
              rate_state   <= RS_IDLE;
              o_rate_value <= 20'h0;
              if (live_mode)
                live_freq <= 20'h0;
            end
            else if (fall_a)
              edges <= edges + 16'h1;
          end
          default: rate_state <= RS_IDLE;
        endcase
      end
      if (apb_wr && (i_paddr == `PRM_SCALE_A_OFS || i_paddr == `PRM_CTRL_OFS))
        req_sfa <= 1'b1;
      if (apb_wr && (i_paddr == `PRM_SCALE_B_OFS || i_paddr == `PRM_CTRL_OFS))
        req_sfb <= 1'b1;
      if (!div_busy && (req_rate || req_sfa || req_sfb))
      begin
        div_busy <= 1'b1;
        div_cnt  <= 6'd56;
        div_quo  <= next_num;
        div_rem  <= 49'h0;
        div_den  <= next_den;
        div_job  <= req_rate ? JB_RATE : (req_sfa ? JB_SFA : JB_SFB);
        if (req_rate && !(rate_en && rate_state == RS_RUN && fall_a))
          req_rate <= 1'b0;
        else if (!req_rate && req_sfa && !apb_wr)
          req_sfa <= 1'b0;
        else if (!req_rate && !req_sfa && !apb_wr)
          req_sfb <= 1'b0;
      end
      else if (div_busy && div_cnt != 6'h0)
      begin
        div_cnt <= div_cnt - 6'h1;
        if (div_try >= {1'b0, div_den})
        begin
          div_rem <= div_try - {1'b0, div_den};
          div_quo <= {div_quo[54:0], 1'b1};
        end
        else
        begin
          div_rem <= div_try;
          div_quo <= {div_quo[54:0], 1'b0};
        end
      end
      else if (div_busy)
      begin
        div_busy <= 1'b0;
        case (div_job)
          // (RQ1) factor with decimal weight
          JB_SFA:  sf_a <= (div_den == 48'h0) ? `PRM_VAL_MAX : div_res;
          JB_SFB:  sf_b <= (div_den == 48'h0) ? `PRM_VAL_MAX : div_res;
          default:
          begin
            // (RQ17) live frequency shown in tenths of hertz
            if (live_mode)
              live_freq <= div_res;
            if (rate_en && rate_state == RS_RUN)
              o_rate_value <= (div_den == 48'h0) ? 20'h0 : div_res;
          end
        endcase
      end
    end
  end

endmodule

// File: inc/prm_regs.vh
`ifndef PRM_REGS_VH
`define PRM_REGS_VH

// Register byte offsets.
`define PRM_CTRL_OFS        8'h00
`define PRM_SCALE_A_OFS     8'h04
`define PRM_SCALE_B_OFS     8'h08
`define PRM_RATE_DISP_OFS   8'h0C
`define PRM_RATE_INP_OFS    8'h10
`define PRM_UPDT_OFS        8'h14
`define PRM_SF_A_OFS        8'h18
`define PRM_SF_B_OFS        8'h1C
`define PRM_CNT_A_OFS       8'h20
`define PRM_CNT_B_OFS       8'h24
`define PRM_RATE_OFS        8'h28
`define PRM_STATUS_OFS      8'h2C

// Control register field positions.
`define PRM_CTRL_FUNC_LSB   0
`define PRM_CTRL_ASSIGN_LSB 4
`define PRM_CTRL_POL_BIT    6
`define PRM_CTRL_BEN_BIT    7
`define PRM_CTRL_RATE_BIT   8
`define PRM_CTRL_RDP_LSB    9
`define PRM_CTRL_APPLY_BIT  12
`define PRM_CTRL_DPA_LSB    13
`define PRM_CTRL_DPB_LSB    16
`define PRM_CTRL_WMASK      32'h0007FFFF

// Reset values.
`define PRM_CTRL_RST        32'h00000050
`define PRM_SCALE_RST       32'h00010001
`define PRM_RATE_DISP_RST   20'h00001
`define PRM_RATE_INP_RST    24'h00000A
`define PRM_LOW_RST         14'h000A
`define PRM_HIGH_RST        10'h014
`define PRM_SF_UNITY        20'h02710

// User input functions.
`define PRM_FN_NONE         4'h0
`define PRM_FN_LOCK         4'h1
`define PRM_FN_INHIBIT      4'h2
`define PRM_FN_RESET        4'h3
`define PRM_FN_STORE        4'h4
`define PRM_FN_STORE_RST    4'h5
`define PRM_FN_DISP_SEL     4'h6
`define PRM_FN_INTENSITY    4'h7
`define PRM_FN_SP1_RST      4'h8
`define PRM_FN_SP2_RST      4'h9
`define PRM_FN_SP12_RST     4'hA

// Timing: clock rate and the 1 ms time base.
`define PRM_CLK_HZ          10000000
`define PRM_TICK_MS         1
`define PRM_CYC_PER_MS      ((`PRM_CLK_HZ / 1000) * `PRM_TICK_MS)
`define PRM_MS_PER_TENTH    100
`define PRM_SF_ONE          10000
`define PRM_VAL_MAX         20'hF423F

`endif

// File: verification/prm_pulse_src.sv
module prm_pulse_src (
  // Clock and burst control
  input  wire logic       i_ref_clk,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  // Pulse lines
  output wire logic       o_pulse_a,
  output wire logic       o_pulse_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  logic       lvl = 1'b1;

  // Pulse A rests high outside bursts, so each burst opens with a falling edge on A; pulse B is its inverse and opens with a rising edge.
  always @(posedge i_ref_clk)
    if (!i_run)
    begin
      cnt <= 8'h00;
      lvl <= 1'b1;
    end
    else if (cnt == i_half - 8'h01)
    begin
      cnt <= 8'h00;
      lvl <= !lvl;
    end
    else
      cnt <= cnt + 8'h01;

  assign o_pulse_a = lvl;
  assign o_pulse_b = !lvl;
endmodule

// File: verification/prm_input_assertions.sv
`include "prm_regs.vh"

module prm_checker #(
  parameter CYC_PER_MS = 10000
) (
  // Clock, reset and bus
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  // User side
  input wire logic        i_user_in,
  input wire logic [19:0] o_count_a_value,
  input wire logic [19:0] o_rate_value,
  input wire logic        o_disp_sel_step,
  input wire logic        o_intensity_step,
  input wire logic        o_sp1_reset,
  input wire logic        o_prog_lockout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctrl;
  wire  [3:0]  fn   = ctrl[3:0];
  wire         act  = i_user_in == ctrl[6];
  wire         on_a = !ctrl[7] || ctrl[4];

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  // Shadow of the control word, taken where a write completes.
  always @(posedge i_ref_clk)
    if (i_sys_rst)
      ctrl <= `PRM_CTRL_RST;
    else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `PRM_CTRL_OFS)
      ctrl <= i_pwdata & `PRM_CTRL_WMASK;

  AST_DSEL_EDGE: assert property (fn == 4'h6 && ctrl[6] && $rose(i_user_in) |->
    ##[2:5] o_disp_sel_step ##1 !o_disp_sel_step) else $error("select step");
  AST_DSEL_SRC: assert property (o_disp_sel_step |-> fn == 4'h6) else $error("stray select");
  AST_INT_SRC: assert property (o_intensity_step |-> fn == 4'h7) else $error("stray step");
  AST_SP1_SRC: assert property (o_sp1_reset |-> fn == 4'h8 || fn == 4'hA) else $error("stray reset");
  AST_LOCK_ON: assert property ((fn == 4'h1 && act) [*6] |-> o_prog_lockout) else $error("no lockout");
  AST_LOCK_OFF: assert property ((fn != 4'h1 || !act) [*6] |-> !o_prog_lockout) else $error("lockout");
  AST_FREEZE: assert property (((fn == 4'h2 || fn == 4'h4) && act && on_a) [*8] |->
    $stable(o_count_a_value)) else $error("frozen count moved");
  AST_RATE_OFF: assert property (!ctrl[8] [*4] |-> o_rate_value == 20'h00000) else $error("rate shown");

  cover property (o_disp_sel_step);
  cover property (o_prog_lockout);
  cover property (o_rate_value != 20'h00000);
endmodule

bind prm_input prm_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .i_ref_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .i_user_in,
  .o_count_a_value, .o_rate_value, .o_disp_sel_step, .o_intensity_step, .o_sp1_reset, .o_prog_lockout);

// File: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        usr   = 1'b0;
  logic        run   = 1'b0;
  logic [7:0]  half  = 8'h04;
  wire  [31:0] rdata;
  wire  [19:0] ca, cb, rate;
  wire  [2:0]  rpt;
  wire         rdy, err, pa, pb, dsel, inten, sp1, sp2, lock;
  int          failures = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          ev[4]    = '{0, 0, 0, 0};

  always #50 clk = ~clk;

  prm_input #(.CYC_PER_MS(10)) u_dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err), .i_pulse_a(pa), .i_pulse_b(pb),
    .i_user_in(usr), .i_reset_key(1'b0), .i_parameter_key(1'b0), .o_count_a_value(ca),
    .o_count_b_value(cb), .o_rate_value(rate), .o_rate_point_position(rpt), .o_disp_sel_step(dsel),
    .o_intensity_step(inten), .o_sp1_reset(sp1), .o_sp2_reset(sp2), .o_prog_lockout(lock));
  prm_pulse_src u_src (.i_ref_clk(clk), .i_run(run), .i_half(half), .o_pulse_a(pa), .o_pulse_b(pb));

  always @(posedge clk)
  begin
    cyc++;
    ev[0] += dsel;
    ev[1] += inten;
    ev[2] += sp1;
    ev[3] += sp2;
    if (cyc == 30000)
    begin
      failures++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input logic [19:0] got);
    checks++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      failures++;
      $display("mismatch %s expected %0d to %0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel  <= 1'b1;
    pwr   <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    r = rdata;
    e = err;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic pulses(input int n);
    run <= 1'b1;
    repeat (2 * n * half) @(posedge clk);
    run <= 1'b0;
    repeat (200) @(posedge clk);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk("ctrl reset", 32'h00000050, r);
    apb(1'b0, 8'h3C, 32'h0, r, e);
    chk("unmapped read", 32'h0, r);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk("hidden rate", 32'h0, r);
    wr(8'h00, 32'h00000150);
    apb(1'b1, 8'h14, 32'h00010002, r, e);
    chk("update order", 32'h1, {31'h0, e});
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("update times", 32'h0014000A, r);
    wr(8'h00, 32'h00000050);
  endtask

  task automatic t_scale;
    pulses(3);
    chk("raw count", 32'h3, {12'h0, ca});
    wr(8'h04, 32'h00800001);
    wr(8'h00, 32'h00004050);
    pulses(128);
    chk("fraction factor", 131 * 7812 / 10000, {12'h0, ca});
    wr(8'h04, 32'h0001000C);
    wr(8'h00, 32'h00000050);
    repeat (200) @(posedge clk);
    chk("whole factor", 131 * 12, {12'h0, ca});
  endtask

  task automatic t_level;
    wr(8'h00, 32'h00000063);
    usr <= 1'b1;
    pulses(2);
    chk("held reset", 32'h0, {12'h0, ca});
    wr(8'h00, 32'h00000052);
    pulses(2);
    wr(8'h00, 32'h00000054);
    pulses(2);
    chk("stored", 32'h0, {12'h0, ca});
    usr <= 1'b0;
    repeat (200) @(posedge clk);
    chk("released", 32'd24, {12'h0, ca});
    wr(8'h00, 32'h00000011);
    repeat (20) @(posedge clk);
    chk("low lockout", 32'h1, {31'h0, lock});
    usr <= 1'b1;
    repeat (20) @(posedge clk);
    chk("lockout off", 32'h0, {31'h0, lock});
    usr <= 1'b0;
    wr(8'h00, 32'h000000F5);
    pulses(2);
    usr <= 1'b1;
    repeat (20) @(posedge clk);
    chk("stored a", 32'd48, {12'h0, ca});
    chk("stored b", 32'd2, {12'h0, cb});
    usr <= 1'b0;
    pulses(1);
    usr <= 1'b1;
    repeat (20) @(posedge clk);
    chk("reset b", 32'd1, {12'h0, cb});
    usr <= 1'b0;
  endtask

  task automatic t_edge;
    int b[4];
    for (int f = 6; f <= 10; f++)
    begin
      wr(8'h00, 32'h00000040 | f);
      b = ev;
      usr <= 1'b1;
      repeat (10) @(posedge clk);
      usr <= 1'b0;
      repeat (10) @(posedge clk);
      chk("select steps", f == 6, ev[0] - b[0]);
      chk("intensity steps", f == 7, ev[1] - b[1]);
      chk("sp1 resets", f == 8 || f == 10, ev[2] - b[2]);
      chk("sp2 resets", f == 9 || f == 10, ev[3] - b[3]);
    end
  endtask

  task automatic t_rate;
    int n = 0;
    wr(8'h00, 32'h00000B50);
    wr(8'h14, 32'h00020001);
    half <= 8'h32;
    run  <= 1'b1;
    while (rate === 20'h00000)
    begin
      @(posedge clk);
      n++;
    end
    chk("late update", 32'h1, n >= 1000);
    rng("rate", 99, 101, rate);
    chk("point", 32'h5, {29'h0, rpt});
    wr(8'h0C, 32'h0000003C);
    repeat (2500) @(posedge clk);
    rng("scaled rate", 5940, 6060, rate);
    run <= 1'b0;
    repeat (2500) @(posedge clk);
    chk("forced zero", 32'h0, {12'h0, rate});
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_scale;
    t_level;
    t_edge;
    t_rate;
    give_verdict;
  end
endmodule
